// ==== hdl/usart_aux_regs.sv ====
// Purpose: Auxiliary configuration, error count and write protection bank
// Assumes: Plain register port, read data in the cycle after the strobe
// Notes:   Mode, baud and timeout registers live outside; only guarded here
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module usart_aux_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Register port
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata_q,
  // Transfer events
  input  wire logic        iso_mode,
  input  wire logic        oversample16,
  input  wire logic        sck_rise,
  input  wire logic        card_error,
  input  wire logic        char_done,
  input  wire logic        tx_pre_start,
  input  wire logic        rx_mid_valid,
  input  wire logic        rx_mid_rising,
  // Settings and status toward the transceiver
  output logic [7:0]       infrared_filter_q,
  output logic             ext_cfg_wr_allow_q,
  output logic             drift_enable_q,
  output logic             card_bit_tick_q,
  output logic             tx_hold_q,
  output logic             tx_pre_active_q,
  output logic             tx_pre_bit_q,
  output logic             tx_pre_first_half_q,
  output logic             rx_bit_q,
  output logic             rx_preamble_found_q
);
  logic [7:0]  guard_gap_bits_q;
  logic [10:0] card_clock_divisor_q;
  logic [7:0]  card_error_count_q;
  logic [31:0] manchester_q;
  logic        protect_enable_q;
  logic        protect_violation_flag_q;
  logic [15:0] protect_violation_source_q;
  logic [3:0]  tx_cnt_q;
  logic [3:0]  rx_cnt_q;
  logic        tick_w;
  logic        hold_w;
  logic        guarded;
  logic        wr_en;
  logic        rd_en;
  logic        violation;
  logic        wr_ok;
  logic        key_ok;
  logic        rx_dec;
  logic        rx_expect;
  logic        tx_pat;

  // Access qualification
  assign wr_en  = ce && wr;
  assign rd_en  = ce && rd;
  assign key_ok = wdata[31:usart_aux_pkg::WP_KEY_LSB] == usart_aux_pkg::WP_KEY;

  // Guarded address decode
  always_comb
  begin
    guarded = (addr == usart_aux_pkg::MODE_ADDR)      ||
              (addr == usart_aux_pkg::BAUD_ADDR)      ||
              (addr == usart_aux_pkg::TIMEOUT_ADDR)   ||
              (addr == usart_aux_pkg::TIMEGUARD_ADDR) ||
              (addr == usart_aux_pkg::RATIO_ADDR)     ||
              (addr == usart_aux_pkg::IRFILT_ADDR)    ||
              (addr == usart_aux_pkg::MANCH_ADDR);
  end

  assign violation = wr_en && guarded && protect_enable_q;
  assign wr_ok     = wr_en && !protect_enable_q;

  // Configuration registers
  // refused unchanged
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      guard_gap_bits_q     <= usart_aux_pkg::GUARD_RESET;
      card_clock_divisor_q <= usart_aux_pkg::RATIO_RESET;
      infrared_filter_q    <= usart_aux_pkg::IRFILT_RESET;
      manchester_q         <= usart_aux_pkg::MANCH_RESET;
    end
    else if (wr_ok)
    begin
      if (addr == usart_aux_pkg::TIMEGUARD_ADDR)
        guard_gap_bits_q <= wdata[7:0];
      if (addr == usart_aux_pkg::RATIO_ADDR)
        card_clock_divisor_q <= wdata[10:0];
      if (addr == usart_aux_pkg::IRFILT_ADDR)
        infrared_filter_q <= wdata[7:0];
      if (addr == usart_aux_pkg::MANCH_ADDR)
        manchester_q <= wdata & usart_aux_pkg::MANCH_MASK;
    end
  end

  // Permission level for outside registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ext_cfg_wr_allow_q <= 1'b1;
    else if (ce)
      ext_cfg_wr_allow_q <= !protect_enable_q;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      protect_enable_q <= 1'b0;
    else if (wr_en && addr == usart_aux_pkg::WPMODE_ADDR && key_ok)
      protect_enable_q <= wdata[usart_aux_pkg::WP_EN_BIT];
  end

  // Violation status; a new violation beats the read clear
  // sticky flag
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      protect_violation_flag_q   <= 1'b0;
      protect_violation_source_q <= 16'h0000;
    end
    else if (violation)
    begin
      protect_violation_flag_q   <= 1'b1;
      protect_violation_source_q <= 16'(addr - usart_aux_pkg::BASE_ADDR);
    end
    else if (rd_en && addr == usart_aux_pkg::WPSTAT_ADDR)
    begin
      protect_violation_flag_q   <= 1'b0;
      protect_violation_source_q <= 16'h0000;
    end
  end

  // Error counter; an error in the read cycle counts as one
  // count errors
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      card_error_count_q <= 8'h00;
    else if (ce)
    begin
      if (rd && addr == usart_aux_pkg::ERRCNT_ADDR)
        card_error_count_q <= {7'h00, card_error};
      else if (card_error && card_error_count_q != 8'hFF)
        card_error_count_q <= card_error_count_q + 8'h01;
    end
  end

  // Read data, valid only in the cycle after the strobe
  // key reads zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_q <= 32'h00000000;
    else if (ce)
    begin
      rdata_q <= 32'h00000000;
      if (rd)
        unique case (addr)
          usart_aux_pkg::TIMEGUARD_ADDR: rdata_q <= {24'h000000, guard_gap_bits_q};
          usart_aux_pkg::RATIO_ADDR:     rdata_q <= {21'h00000, card_clock_divisor_q};
          usart_aux_pkg::ERRCNT_ADDR:    rdata_q <= {24'h000000, card_error_count_q};
          usart_aux_pkg::IRFILT_ADDR:    rdata_q <= {24'h000000, infrared_filter_q};
          usart_aux_pkg::MANCH_ADDR:     rdata_q <= manchester_q;
          usart_aux_pkg::WPMODE_ADDR:    rdata_q <= {31'h0000000, protect_enable_q};
          usart_aux_pkg::WPSTAT_ADDR:    rdata_q <= {8'h00, protect_violation_source_q,
                                                     7'h00, protect_violation_flag_q};
          default:                       rdata_q <= 32'h00000000;
        endcase
    end
  end

  // Smart-card bit clock
  card_clock_divider u_div (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .enable   (iso_mode),
    .sck_rise (sck_rise),
    .divisor  (card_clock_divisor_q),
    .tick_q   (tick_w)
  );

  // Transmit timeguard
  guard_gap_timer u_gap (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .char_done (char_done),
    .bit_tick  (tick_w),
    .gap_bits  (guard_gap_bits_q),
    .hold_q    (hold_w)
  );

  // Output registers for tick and hold
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      card_bit_tick_q <= 1'b0;
      tx_hold_q       <= 1'b0;
      drift_enable_q  <= 1'b0;
    end
    else if (ce)
    begin
      card_bit_tick_q <= tick_w;
      tx_hold_q       <= hold_w;
      drift_enable_q  <= manchester_q[usart_aux_pkg::DRIFT_BIT] && oversample16;
    end
  end

  // Pattern bit for preamble index
  function automatic logic pat_bit(input logic [1:0] pp, input logic [3:0] idx);
    unique case (pp)
      usart_aux_pkg::PRE_ALL_ONE:  pat_bit = 1'b1;
      usart_aux_pkg::PRE_ALL_ZERO: pat_bit = 1'b0;
      usart_aux_pkg::PRE_ZERO_ONE: pat_bit = idx[0];
      usart_aux_pkg::PRE_ONE_ZERO: pat_bit = !idx[0];
    endcase
  endfunction : pat_bit

  assign tx_pat = pat_bit(manchester_q[usart_aux_pkg::TX_PREAMBLE_PATTERN_LSB +: 2], tx_cnt_q);

  // Transmit preamble sequencer
  // tx length
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_pre_active_q     <= 1'b0;
      tx_cnt_q            <= 4'h0;
      tx_pre_bit_q        <= 1'b0;
      tx_pre_first_half_q <= 1'b0;
    end
    else if (ce)
    begin
      if (tx_pre_start)
      begin
        tx_pre_active_q <= (manchester_q[usart_aux_pkg::TX_PREAMBLE_LENGTH_LSB +: 4] != 4'h0);
        tx_cnt_q        <= 4'h0;
      end
      else if (tx_pre_active_q && tick_w)
      begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
        if (tx_cnt_q + 4'h1 == manchester_q[usart_aux_pkg::TX_PREAMBLE_LENGTH_LSB +: 4])
          tx_pre_active_q <= 1'b0;
      end
      tx_pre_bit_q        <= tx_pat;
      tx_pre_first_half_q <= tx_pat ^ manchester_q[usart_aux_pkg::TX_MANCHESTER_POLARITY_BIT];
    end
  end

  assign rx_dec    = !(rx_mid_rising ^ manchester_q[usart_aux_pkg::RX_MANCHESTER_POLARITY_BIT]);
  assign rx_expect = pat_bit(manchester_q[usart_aux_pkg::RX_PREAMBLE_PATTERN_LSB +: 2], rx_cnt_q);

  // Receive decode and preamble detection
  // rx length
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_bit_q            <= 1'b0;
      rx_cnt_q            <= 4'h0;
      rx_preamble_found_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_preamble_found_q <= 1'b0;
      if (rx_mid_valid)
      begin
        rx_bit_q <= rx_dec;
        if (manchester_q[usart_aux_pkg::RX_PREAMBLE_LENGTH_LSB +: 4] == 4'h0 || rx_dec != rx_expect)
          rx_cnt_q <= 4'h0;
        else if (rx_cnt_q + 4'h1 == manchester_q[usart_aux_pkg::RX_PREAMBLE_LENGTH_LSB +: 4])
        begin
          rx_cnt_q            <= 4'h0;
          rx_preamble_found_q <= 1'b1;
        end
        else
          rx_cnt_q <= rx_cnt_q + 4'h1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_ratio_zero;
    card_bit_tick_q |-> $past(card_clock_divisor_q, 2) != 11'h000;
  endproperty
  a_ratio_zero: assert property (p_ratio_zero) else $error("tick with zero ratio");

  property p_err_clear;
    rd_en && addr == usart_aux_pkg::ERRCNT_ADDR && !card_error |=> card_error_count_q == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error count not cleared");

  property p_err_inc;
    ce && card_error && !rd && card_error_count_q < 8'hFF
      |=> card_error_count_q == $past(card_error_count_q) + 8'h01;
  endproperty
  a_err_inc: assert property (p_err_inc) else $error("error not counted");

  property p_bad_key;
    wr_en && addr == usart_aux_pkg::WPMODE_ADDR && !key_ok |=> $stable(protect_enable_q);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("enable changed on bad key");

  property p_refuse;
    wr_en && protect_enable_q |=> $stable(guard_gap_bits_q) && $stable(manchester_q)
      && $stable(card_clock_divisor_q) && $stable(infrared_filter_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected register changed");

  property p_viol;
    violation |=> protect_violation_flag_q
      && protect_violation_source_q == 16'($past(addr) - usart_aux_pkg::BASE_ADDR);
  endproperty
  a_viol: assert property (p_viol) else $error("violation not recorded");

  property p_stat_clear;
    rd_en && addr == usart_aux_pkg::WPSTAT_ADDR && !violation
      |=> !protect_violation_flag_q && protect_violation_source_q == 16'h0000;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

  property p_gap_zero;
    ce && char_done && guard_gap_bits_q == 8'h00 |=> ##1 !tx_hold_q;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("hold with zero gap");

  property p_key_rd;
    rd_en |=> rdata_q[31:8] == 24'h000000 || $past(addr) != usart_aux_pkg::WPMODE_ADDR;
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key read nonzero");

  c_violation: cover property (violation ##1 rd_en && addr == usart_aux_pkg::WPSTAT_ADDR);
  c_hold:      cover property (tx_hold_q ##[1:50] !tx_hold_q);
  c_preamble:  cover property (rx_preamble_found_q);

endmodule : usart_aux_regs

// ==== hdl/usart_aux_pkg.sv ====
// Purpose: Shared constants for the serial auxiliary configuration bank
// Assumes: Byte addresses on a 32-bit word port
// Notes:   Field positions, reset values and keys live only here
package usart_aux_pkg;

  // Register byte addresses
  localparam logic [31:0] BASE_ADDR       = 32'h40024000;
  localparam logic [31:0] MODE_ADDR       = 32'h40024004;
  localparam logic [31:0] BAUD_ADDR       = 32'h40024020;
  localparam logic [31:0] TIMEOUT_ADDR    = 32'h40024024;
  localparam logic [31:0] TIMEGUARD_ADDR  = 32'h40024028;
  localparam logic [31:0] RATIO_ADDR      = 32'h40024040;
  localparam logic [31:0] ERRCNT_ADDR     = 32'h40024044;
  localparam logic [31:0] IRFILT_ADDR     = 32'h4002404C;
  localparam logic [31:0] MANCH_ADDR      = 32'h40024050;
  localparam logic [31:0] WPMODE_ADDR     = 32'h400240E4;
  localparam logic [31:0] WPSTAT_ADDR     = 32'h400240E8;

  // Reset values
  localparam logic [10:0] RATIO_RESET     = 11'h174;
  localparam logic [7:0]  GUARD_RESET     = 8'h00;
  localparam logic [7:0]  IRFILT_RESET    = 8'h00;
  localparam logic [31:0] MANCH_RESET     = 32'h00000000;

  // Manchester field positions
  localparam int TX_PREAMBLE_LENGTH_LSB   = 0;
  localparam int TX_PREAMBLE_PATTERN_LSB   = 8;
  localparam int TX_MANCHESTER_POLARITY_BIT = 12;
  localparam int RX_PREAMBLE_LENGTH_LSB   = 16;
  localparam int RX_PREAMBLE_PATTERN_LSB   = 24;
  localparam int RX_MANCHESTER_POLARITY_BIT = 28;
  localparam int DRIFT_BIT   = 30;
  localparam logic [31:0] MANCH_MASK = 32'h530F_130F;

  // Write protection fields
  localparam int          WP_EN_BIT  = 0;
  localparam int          WP_KEY_LSB = 8;
  localparam logic [23:0] WP_KEY     = 24'h555341;
  localparam int          WP_SRC_LSB = 8;

  // Preamble patterns
  typedef enum logic [1:0] {
    PRE_ALL_ONE  = 2'h0,
    PRE_ALL_ZERO = 2'h1,
    PRE_ZERO_ONE = 2'h2,
    PRE_ONE_ZERO = 2'h3
  } preamble_t;

endpackage : usart_aux_pkg

// ==== hdl/guard_gap_timer.sv ====
// Purpose: Holds the transmit line idle for a set number of bit periods
// Assumes: bit_tick is a one-cycle pulse per bit period
// Notes:   A zero gap never raises the hold
`timescale 1ns/1ps
module guard_gap_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Timing events
  input  wire logic       char_done,
  input  wire logic       bit_tick,
  input  wire logic [7:0] gap_bits,
  // Hold output
  output logic            hold_q
);
  logic [7:0] left_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hold_q <= 1'b0;
      left_q <= 8'h00;
    end
    else if (ce)
    begin
      if (char_done)
      begin
        hold_q <= (gap_bits != 8'h00);
        left_q <= gap_bits;
      end
      else if (hold_q && bit_tick)
      begin
        left_q <= left_q - 8'h01;
        if (left_q == 8'h01)
          hold_q <= 1'b0;
      end
    end
  end

endmodule : guard_gap_timer

// ==== hdl/card_clock_divider.sv ====
// Purpose: Divides serial clock pin edges down to the smart-card bit rate
// Assumes: sck_rise is a synchronous one-cycle pulse per pin rising edge
// Notes:   Divisor zero stops all ticks
`timescale 1ns/1ps
module card_clock_divider (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Source and setting
  input  wire logic        enable,
  input  wire logic        sck_rise,
  input  wire logic [10:0] divisor,
  // Bit tick
  output logic             tick_q
);
  logic [10:0] cnt_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q  <= 11'h000;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      tick_q <= 1'b0;
      if (!enable || divisor == 11'h000)
        cnt_q <= 11'h000;
      else if (sck_rise)
      begin
        if (cnt_q >= divisor - 11'h001)
        begin
          cnt_q  <= 11'h000;
          tick_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 11'h001;
      end
    end
  end

endmodule : card_clock_divider

// ==== tb/line_peer.sv ====
// Purpose: Serial line peer giving card clock edges, card errors and mid-bit edges
// Assumes: Every event is a one-cycle pulse launched after a rising edge
// Notes:   Edge direction flips when idle so a stale value never looks valid
`timescale 1ns/1ps
module line_peer (
  // Clock
  input  wire logic clk,
  // Line events
  output logic      sck_rise,
  output logic      card_error,
  output logic      rx_mid_valid,
  output logic      rx_mid_rising
);
  // Idle levels at time zero
  initial
  begin
    sck_rise      = 1'b0;
    card_error    = 1'b0;
    rx_mid_valid  = 1'b0;
    rx_mid_rising = 1'b0;
  end

  // Card clock pin edges, one idle cycle apart
  task automatic send_sck(input int n);
    repeat (n)
    begin
      @(posedge clk) sck_rise <= 1'b1;
      @(posedge clk) sck_rise <= 1'b0;
    end
  endtask : send_sck

  // One transfer error event
  task automatic send_err();
    @(posedge clk) card_error <= 1'b1;
    @(posedge clk) card_error <= 1'b0;
  endtask : send_err

  // One mid-bit transition, direction inverted afterwards
  task automatic send_mid(input logic rising);
    @(posedge clk);
    rx_mid_valid  <= 1'b1;
    rx_mid_rising <= rising;
    @(posedge clk);
    rx_mid_valid  <= 1'b0;
    rx_mid_rising <= ~rising;
    @(posedge clk);
  endtask : send_mid
endmodule : line_peer

// ==== tb/usart_aux_regs_tb_top.sv ====
// Purpose: Self-checking bench for the auxiliary configuration bank
// Assumes: Register port with read data in the cycle after the strobe
// Notes:   Line events come from the peer model
`timescale 1ns/1ps
module usart_aux_regs_tb_top;
  // Bench signals
  logic        clk = 1'b0;
  logic        reset, ce, wr, rd, iso_mode, oversample16, char_done, tx_pre_start;
  logic [31:0] addr, wdata, rdata_q;
  logic        sck_rise, card_error, rx_mid_valid, rx_mid_rising;
  logic [7:0]  infrared_filter_q;
  logic        ext_cfg_wr_allow_q, drift_enable_q, card_bit_tick_q, tx_hold_q;
  logic        tx_pre_active_q, rx_bit_q, rx_preamble_found_q;
  logic        tx_pre_bit_q, tx_pre_first_half_q;
  int          mismatches, num_checks, cycles, tick_cnt, hold_cnt, found_cnt, pre_cnt;
  logic [31:0] guarded [7];
  logic [31:0] rx_cfg [3];

  // Device under test
  usart_aux_regs u_dut (.clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .iso_mode(iso_mode), .oversample16(oversample16), .sck_rise(sck_rise),
    .card_error(card_error), .char_done(char_done), .tx_pre_start(tx_pre_start),
    .rx_mid_valid(rx_mid_valid), .rx_mid_rising(rx_mid_rising), .infrared_filter_q(infrared_filter_q),
    .ext_cfg_wr_allow_q(ext_cfg_wr_allow_q), .drift_enable_q(drift_enable_q),
    .card_bit_tick_q(card_bit_tick_q), .tx_hold_q(tx_hold_q), .tx_pre_active_q(tx_pre_active_q),
    .tx_pre_bit_q(tx_pre_bit_q), .tx_pre_first_half_q(tx_pre_first_half_q),
    .rx_bit_q(rx_bit_q), .rx_preamble_found_q(rx_preamble_found_q));

  // Serial line peer
  line_peer u_peer (.clk(clk), .sck_rise(sck_rise), .card_error(card_error),
    .rx_mid_valid(rx_mid_valid), .rx_mid_rising(rx_mid_rising));

  // Clock
  always #12.5 clk = ~clk;

  // Event counters and hang limit
  always @(posedge clk)
  begin
    cycles++;
    if (card_bit_tick_q === 1'b1) tick_cnt++;
    if (tx_hold_q === 1'b1) hold_cnt++;
    if (rx_preamble_found_q === 1'b1) found_cnt++;
    if (tx_pre_active_q === 1'b1) pre_cnt++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // Verdict and end of run
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Compare and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      mismatches++;
  endtask : check

  // One-cycle register write
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // One-cycle register read, data checked in the following cycle
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata_q, exp);
  endtask : rd_chk

  // Let edges pass, then sample settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Main sequence
  initial
  begin
    reset = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 32'h0; wdata = 32'h0;
    iso_mode = 1'b0; oversample16 = 1'b0; char_done = 1'b0; tx_pre_start = 1'b0;
    guarded = '{usart_aux_pkg::MODE_ADDR, usart_aux_pkg::BAUD_ADDR, usart_aux_pkg::TIMEOUT_ADDR,
      usart_aux_pkg::TIMEGUARD_ADDR, usart_aux_pkg::RATIO_ADDR, usart_aux_pkg::IRFILT_ADDR, usart_aux_pkg::MANCH_ADDR};
    rx_cfg = '{32'h0002_0000, 32'h0102_0000, 32'h1002_0000};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    // Reset values, unmapped place
    check(32'(ext_cfg_wr_allow_q), 32'h1);
    rd_chk(usart_aux_pkg::RATIO_ADDR, 32'h0000_0174);
    rd_chk(usart_aux_pkg::TIMEGUARD_ADDR, 32'h0);
    rd_chk(usart_aux_pkg::WPSTAT_ADDR, 32'h0);
    rd_chk(32'h4002_4100, 32'h0);
    // Field widths on write and readback
    wr_reg(usart_aux_pkg::TIMEGUARD_ADDR, 32'hFFFF_FFFF);
    rd_chk(usart_aux_pkg::TIMEGUARD_ADDR, 32'h0000_00FF);
    wr_reg(usart_aux_pkg::RATIO_ADDR, 32'hFFFF_FFFF);
    rd_chk(usart_aux_pkg::RATIO_ADDR, 32'h0000_07FF);
    wr_reg(usart_aux_pkg::IRFILT_ADDR, 32'hFFFF_FFA5);
    rd_chk(usart_aux_pkg::IRFILT_ADDR, 32'h0000_00A5);
    check(32'(infrared_filter_q), 32'h0000_00A5);
    wr_reg(usart_aux_pkg::MANCH_ADDR, 32'hFFFF_FFFF);
    rd_chk(usart_aux_pkg::MANCH_ADDR, 32'h530F_130F);
    // Drift needs sixteen-times mode
    check(32'(drift_enable_q), 32'h0);
    oversample16 <= 1'b1;
    settle(2);
    check(32'(drift_enable_q), 32'h1);
    // Transmit preamble off, then one bit long
    wr_reg(usart_aux_pkg::MANCH_ADDR, 32'h0);
    pre_cnt = 0;
    @(posedge clk) tx_pre_start <= 1'b1;
    @(posedge clk) tx_pre_start <= 1'b0;
    settle(3);
    check(32'(pre_cnt), 32'h0);
    wr_reg(usart_aux_pkg::MANCH_ADDR, 32'h0000_0001);
    @(posedge clk) tx_pre_start <= 1'b1;
    @(posedge clk) tx_pre_start <= 1'b0;
    settle(2);
    check(32'(tx_pre_active_q), 32'h1);
    // Preamble pattern and first-half level at index zero
    for (int p = 0; p < 4; p++)
    begin
      wr_reg(usart_aux_pkg::MANCH_ADDR, 32'h0000_0001 | (32'(p) << 8) | (32'(p & 1) << 12));
      settle(2);
      check(32'(tx_pre_bit_q), 32'(p == 0 || p == 3));
      check(32'(tx_pre_first_half_q), 32'((p == 0 || p == 3) ^ (p & 1)));
    end
    // Receive preamble of two bits, pattern and polarity
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(usart_aux_pkg::MANCH_ADDR, rx_cfg[i]);
      settle(1);
      found_cnt = 0;
      repeat (2) u_peer.send_mid(i != 0);
      settle(3);
      check(32'(found_cnt), 32'h1);
      check(32'(rx_bit_q), (i == 1) ? 32'h0 : 32'h1);
    end
    // Error counter clears on read
    repeat (3) u_peer.send_err();
    rd_chk(usart_aux_pkg::ERRCNT_ADDR, 32'h3);
    rd_chk(usart_aux_pkg::ERRCNT_ADDR, 32'h0);
    // Card clock division by three, then by zero
    iso_mode <= 1'b1;
    wr_reg(usart_aux_pkg::RATIO_ADDR, 32'h3);
    settle(1);
    tick_cnt = 0;
    u_peer.send_sck(9);
    settle(4);
    check(32'(tick_cnt), 32'h3);
    wr_reg(usart_aux_pkg::RATIO_ADDR, 32'h0);
    settle(1);
    tick_cnt = 0;
    u_peer.send_sck(9);
    settle(4);
    check(32'(tick_cnt), 32'h0);
    // Guard gap of zero, then of two bits
    wr_reg(usart_aux_pkg::RATIO_ADDR, 32'h1);
    for (int g = 0; g < 3; g += 2)
    begin
      wr_reg(usart_aux_pkg::TIMEGUARD_ADDR, 32'(g));
      settle(1);
      hold_cnt = 0;
      @(posedge clk) char_done <= 1'b1;
      @(posedge clk) char_done <= 1'b0;
      u_peer.send_sck(6);
      settle(2);
      check(32'(hold_cnt > 0), 32'(g > 0));
    end
    // Key checked on protect enable
    wr_reg(usart_aux_pkg::WPMODE_ADDR, 32'h5553_4201);
    rd_chk(usart_aux_pkg::WPMODE_ADDR, 32'h0);
    wr_reg(usart_aux_pkg::WPMODE_ADDR, 32'h5553_4101);
    rd_chk(usart_aux_pkg::WPMODE_ADDR, 32'h1);
    check(32'(ext_cfg_wr_allow_q), 32'h0);
    wr_reg(usart_aux_pkg::WPMODE_ADDR, 32'h0);
    rd_chk(usart_aux_pkg::WPMODE_ADDR, 32'h1);
    // Refused writes report their offset
    foreach (guarded[i])
    begin
      wr_reg(guarded[i], 32'h0000_0077);
      rd_chk(usart_aux_pkg::WPSTAT_ADDR, {8'h00, 16'(guarded[i] - usart_aux_pkg::BASE_ADDR), 8'h01});
    end
    rd_chk(usart_aux_pkg::WPSTAT_ADDR, 32'h0);
    rd_chk(usart_aux_pkg::TIMEGUARD_ADDR, 32'h2);
    rd_chk(usart_aux_pkg::RATIO_ADDR, 32'h1);
    rd_chk(usart_aux_pkg::IRFILT_ADDR, 32'h0000_00A5);
    // Unlock restores write access
    wr_reg(usart_aux_pkg::WPMODE_ADDR, 32'h5553_4100);
    settle(2);
    check(32'(ext_cfg_wr_allow_q), 32'h1);
    wr_reg(usart_aux_pkg::TIMEGUARD_ADDR, 32'h9);
    rd_chk(usart_aux_pkg::TIMEGUARD_ADDR, 32'h9);
    print_verdict();
  end
endmodule : usart_aux_regs_tb_top
